// ### include/seg_rx_pkg.sv
// shared constants and carrier types for the segmented receive packet port
package seg_rx_pkg;

  // bus geometry
  localparam int SEG_COUNT    = 4;
  localparam int SEG_BITS     = 128;
  localparam int SEG_BYTES    = 16;
  localparam int EMPTY_BITS   = 4;

  // empty-count field layout under an error flag
  localparam int EMPTY_LOW_MSB = 2;
  localparam logic [2:0] EMPTY_LOW_ERR = 3'h0;

  // reset synchroniser depth in stages
  localparam int RST_SYNC_STAGES = 2;

  // buffer geometry
  localparam int BUF_DEPTH = 2;

  // clock figures
  localparam int CLK_PERIOD_PS  = 8000;
  localparam int RST_MIN_PS     = 5000;
  localparam int RST_MIN_CYCLES = (RST_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // one segment as seen on the user side
  typedef struct packed {
    logic                  valid;
    logic                  first;
    logic                  last;
    logic                  bad;
    logic [EMPTY_BITS-1:0] empty_bytes;
    logic [SEG_BITS-1:0]   data;
  } seg_t;

  // one whole beat of four segments, segment 0 in the low slot
  typedef seg_t [SEG_COUNT-1:0] beat_t;

  localparam int BEAT_BITS = $bits(beat_t);

endpackage

// ### rtl/beat_buffer.sv
// two-entry valid/ready buffer holding whole receive beats
`timescale 1ns/1ps
module beat_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_n,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];  // storage
  logic [PW-1:0]    wr_q;           // write slot
  logic [PW-1:0]    rd_q;           // read slot
  logic [PW:0]      cnt_q;          // fill level
  logic             push;
  logic             pop;

  // honest full and empty
  // full compares at the level's own width, a pointer-wide depth would wrap to zero
  assign in_ready  = (cnt_q != (PW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign out_valid = (cnt_q != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_q[rd_q];

  // pointer and level bookkeeping
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    end
  end

  // storage has no reset, contents are gated by the level
  always_ff @(posedge mclk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

endmodule

// ### rtl/segmented_rx_packet_port.sv
// receive half of the segmented local packet bus toward user logic
// What this block does
// - transmit signals timed on transmit clock edge
// - receive signals timed on receive clock edge
// - core synchronises receive and transmit resets internally
// - four 128-bit segments, data valid when enabled
// - enable qualifies every other segment signal
// - first flag marks packet's opening segment
// - last flag marks packet's closing segment
// - bad flag meaningful only with last
// - low bad flag means packet clean
// - empty count gives unused bytes at end
// - bad forces low three empty bits zero
`timescale 1ns/1ps
module segmented_rx_packet_port (
  // single clock, shared by both directions here
  input  wire logic                  mclk,
  input  wire logic                  rstn,
  // per-direction resets, active high, asynchronous
  input  wire logic                  rx_reset,
  input  wire logic                  tx_reset,
  // receive beats from the mac core, same clock domain
  input  wire seg_rx_pkg::beat_t     core_beat,
  output logic                       core_ready,
  // segmented local packet bus toward user logic
  output seg_rx_pkg::beat_t          receive_segment,
  input  wire logic                  user_ready,
  // synchronised reset levels for the transmit half
  output logic                       tx_reset_sync
);

  // synchroniser chains, stage 0 only feeds stage 1
  logic [seg_rx_pkg::RST_SYNC_STAGES-1:0] rx_rst_sync_q;
  logic [seg_rx_pkg::RST_SYNC_STAGES-1:0] tx_rst_sync_q;
  logic                                   rx_in_reset;   // receive side held
  logic                                   rx_buf_rstn;   // buffer reset, low active

  // cleaned beat entering the buffer
  seg_rx_pkg::beat_t                      clean_beat;
  logic                                   any_valid;
  logic                                   buf_in_ready;
  logic                                   buf_out_valid;
  logic [seg_rx_pkg::BEAT_BITS-1:0]       buf_out_data;
  seg_rx_pkg::beat_t                      buf_beat;
  logic                                   take_out;

  // receive reset sampled on the clock, both assertion and release pass through the stages
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rx_rst_sync_q <= '1;
    end else begin
      rx_rst_sync_q <= {rx_rst_sync_q[0], rx_reset};
    end
  end

  // transmit reset synchronised the same way
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tx_rst_sync_q <= '1;
    end else begin
      tx_rst_sync_q <= {tx_rst_sync_q[0], tx_reset};
    end
  end

  // only the final stage is ever read
  assign rx_in_reset = rx_rst_sync_q[seg_rx_pkg::RST_SYNC_STAGES-1];

  // transmit level handed on from a flop
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tx_reset_sync <= 1'b1;
    end else begin
      tx_reset_sync <= tx_rst_sync_q[seg_rx_pkg::RST_SYNC_STAGES-1];
    end
  end

  // buffer held empty while receive reset stands
  // rx_in_reset comes from a flop, rstn straight from the input port
  assign rx_buf_rstn = rstn & ~rx_in_reset;

  // per-segment cleanup before buffering
  always_comb begin
    clean_beat = '0;
    any_valid  = 1'b0;
    for (int s = 0; s < seg_rx_pkg::SEG_COUNT; s++) begin
      // disabled segment shows all flags low
      if (core_beat[s].valid) begin
        any_valid                = 1'b1;
        clean_beat[s].valid      = 1'b1;
        clean_beat[s].data       = core_beat[s].data;
        clean_beat[s].first      = core_beat[s].first;
        clean_beat[s].last       = core_beat[s].last;
        // bad flag kept only with last
        clean_beat[s].bad        = core_beat[s].bad & core_beat[s].last;
        // empty count kept only with last
        if (core_beat[s].last) begin
          clean_beat[s].empty_bytes = core_beat[s].empty_bytes;
        end
        // error forces low three empty bits
        if (core_beat[s].bad) begin
          clean_beat[s].empty_bytes[seg_rx_pkg::EMPTY_LOW_MSB:0] =
            seg_rx_pkg::EMPTY_LOW_ERR;
        end
      end
    end
  end

  // a clean packet shows bad low, passed as-is

  // back-pressure reaches the core; idle beats never occupy space
  assign core_ready = buf_in_ready & ~rx_in_reset;

  // two-entry buffer so a user stall loses no beat
  beat_buffer #(
    .WIDTH (seg_rx_pkg::BEAT_BITS),
    .DEPTH (seg_rx_pkg::BUF_DEPTH)
  ) u_buf (
    .mclk      (mclk),
    .rst_n     (rx_buf_rstn),
    .in_valid  (any_valid & ~rx_in_reset),
    .in_ready  (buf_in_ready),
    .in_data   (clean_beat),
    .out_valid (buf_out_valid),
    .out_ready (take_out),
    .out_data  (buf_out_data)
  );

  assign buf_beat = seg_rx_pkg::beat_t'(buf_out_data);

  // output slot empties when user takes it or it is idle
  assign take_out = buf_out_valid & ~rx_in_reset &
                    (user_ready | ~(|{receive_segment[3].valid, receive_segment[2].valid,
                                      receive_segment[1].valid, receive_segment[0].valid}));

  // output register launched on the clock edge
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      receive_segment <= '0;
    end else if (rx_in_reset) begin
      // receive reset clears the bus
      receive_segment <= '0;
    end else if (take_out) begin
      receive_segment <= buf_beat;
    end else if (user_ready) begin
      // beat consumed, nothing new
      receive_segment <= '0;
    end
  end

  // transmit half lives elsewhere, sharing this clock

endmodule

// ### tb/seg_rx_chk.sv
// port assertions for the segmented receive port
`timescale 1ns/1ps
module seg_rx_chk (
  // clock and resets
  input wire logic              mclk,
  input wire logic              rstn,
  input wire logic              rx_reset,
  input wire logic              tx_reset,
  // core side
  input wire seg_rx_pkg::beat_t core_beat,
  input wire logic              core_ready,
  // user side
  input wire seg_rx_pkg::beat_t receive_segment,
  input wire logic              user_ready,
  input wire logic              tx_reset_sync
);
  logic out_any, take, idle_dirty, bad_alone, err_empty, early_empty; // beat summaries
  // fold four segments into summary bits
  always_comb begin
    {out_any, take, idle_dirty, bad_alone, err_empty, early_empty} = 6'h00;
    for (int s = 0; s < seg_rx_pkg::SEG_COUNT; s++) begin
      out_any |= receive_segment[s].valid;
      take |= core_beat[s].valid & core_ready;
      idle_dirty |= !receive_segment[s].valid && (receive_segment[s] != '0);
      bad_alone |= receive_segment[s].bad && !receive_segment[s].last;
      err_empty |= receive_segment[s].bad && (receive_segment[s].empty_bytes[2:0] != 3'h0);
      early_empty |= !receive_segment[s].last && (receive_segment[s].empty_bytes != 4'h0);
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  hold_stall_a: assert property (out_any && !user_ready && !rx_reset |=> $stable(receive_segment))
    else $error("output beat moved while stalled");
  idle_zero_a: assert property (!idle_dirty)
    else $error("disabled segment not cleared");
  bad_last_a: assert property (!bad_alone)
    else $error("bad flag without last flag");
  err_empty_a: assert property (!err_empty)
    else $error("bad segment with low empty bits set");
  last_empty_a: assert property (!early_empty)
    else $error("empty count on a non-last segment");
  rx_block_a: assert property (rx_reset[*3] |-> !core_ready ##1 receive_segment == '0)
    else $error("receive reset did not block and clear");
  tx_sync_hi_a: assert property (tx_reset[*4] |-> tx_reset_sync)
    else $error("transmit reset not passed through");
  tx_sync_lo_a: assert property (!tx_reset[*4] |-> !tx_reset_sync)
    else $error("transmit reset stuck high");
  beat_flow_a: assert property (take |-> ##[1:8] (out_any || !user_ready || rx_reset))
    else $error("accepted beat never presented");
  // main scenarios seen
  cover property (out_any && !user_ready);
  cover property (take && out_any);
  cover property (rx_reset[*4]);
endmodule
bind segmented_rx_packet_port seg_rx_chk seg_rx_chk_i (.mclk, .rstn, .rx_reset, .tx_reset,
  .core_beat, .core_ready, .receive_segment, .user_ready, .tx_reset_sync);

// ### tb/user_sink.sv
// user-side receiver model that stalls on command
`timescale 1ns/1ps
module user_sink (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rstn,
  // stall pattern select
  input  wire logic slow,
  // back-pressure to the port
  output logic      user_ready
);
  logic [1:0] tick_q; // stall phase, ready one cycle in four when slow
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tick_q     <= 2'h0;
      user_ready <= 1'b0;
    end else begin
      tick_q     <= tick_q + 2'h1;
      user_ready <= !slow || (tick_q == 2'h3);
    end
  end
endmodule

// ### tb/segmented_rx_packet_port_tb.sv
// self-checking bench for the segmented receive port
`timescale 1ns/1ps
module segmented_rx_packet_port_tb;
  logic              mclk, rstn, rx_reset, tx_reset, gen, slow; // bench-driven controls
  logic              user_ready, core_ready, tx_reset_sync;     // handshake and sync
  seg_rx_pkg::beat_t core_beat, receive_segment;                // both sides of the port
  seg_rx_pkg::beat_t exp_q[$];                                  // notes, oldest first
  logic [31:0]       lfsr_s;                                    // random state
  int                fail_count, comparisons, cycles;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // any segment enabled
  function automatic logic live(input seg_rx_pkg::beat_t b);
    return b[0].valid | b[1].valid | b[2].valid | b[3].valid;
  endfunction
  // user view of one accepted core beat
  function automatic seg_rx_pkg::beat_t clean(input seg_rx_pkg::beat_t b);
    seg_rx_pkg::beat_t r;
    r = b;
    for (int s = 0; s < seg_rx_pkg::SEG_COUNT; s++) begin
      r[s].bad = b[s].bad & b[s].last;
      if (!b[s].last) r[s].empty_bytes = 4'h0;
      if (r[s].bad) r[s].empty_bytes[2:0] = seg_rx_pkg::EMPTY_LOW_ERR;
      if (!b[s].valid) r[s] = '0;
    end
    return r;
  endfunction
  task automatic chk(input string n, input logic [seg_rx_pkg::BEAT_BITS-1:0] e, s);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  segmented_rx_packet_port segmented_rx_packet_port_i (.mclk, .rstn, .rx_reset, .tx_reset,
    .core_beat, .core_ready, .receive_segment, .user_ready, .tx_reset_sync);
  user_sink user_sink_i (.mclk, .rstn, .slow, .user_ready);
  // one clock stands in for both matched directions
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // driver: note taken beats, hold refused ones, bound the run
  always @(posedge mclk) begin
    seg_rx_pkg::beat_t nb;
    cycles++;
    if (cycles > 5000) begin
      fail_count++;
      give_verdict();
    end
    if (core_ready && live(core_beat)) exp_q.push_back(clean(core_beat));
    if (!gen) core_beat <= '0;
    else if (core_ready || !live(core_beat)) begin
      for (int i = 0; i < seg_rx_pkg::BEAT_BITS / 32; i++) begin
        lfsr_s = lfsr(lfsr_s);
        nb = {nb, lfsr_s};
      end
      core_beat <= nb;
    end
  end
  // monitor: each presented beat against the oldest note
  always @(posedge mclk) begin
    if (rstn && user_ready && live(receive_segment)) begin
      if (exp_q.size() == 0) chk("spare beat", '0, receive_segment);
      else chk("beat", exp_q.pop_front(), receive_segment);
    end
  end
  initial begin
    {rstn, rx_reset, tx_reset, gen, slow} = 5'h00;
    core_beat = '0;
    lfsr_s = 32'hBD5D6A77;
    {fail_count, comparisons, cycles} = '0;
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
    gen <= 1'b1;
    repeat (300) @(posedge mclk);
    slow <= 1'b1;
    repeat (300) @(posedge mclk);
    gen <= 1'b0;
    repeat (60) @(posedge mclk);
    chk("drained", 0, exp_q.size());
    rx_reset <= 1'b1;
    tx_reset <= 1'b1;
    repeat (3) @(posedge mclk);
    gen <= 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    chk("core_ready", 0, core_ready);
    chk("tx_reset_sync", 1, tx_reset_sync);
    chk("cleared", '0, receive_segment);
    @(posedge mclk);
    {gen, rx_reset, tx_reset, slow} <= 4'h0;
    repeat (4) @(posedge mclk);
    #1;
    chk("tx_reset_sync", 0, tx_reset_sync);
    gen <= 1'b1;
    repeat (200) @(posedge mclk);
    gen <= 1'b0;
    repeat (60) @(posedge mclk);
    chk("drained", 0, exp_q.size());
    give_verdict();
  end
endmodule
